/* File: verilog/hbp_regs.svh */
// Purpose: Timing counts and decode constants for the host bus port.
// Assumes: Device clock of 100 MHz.
// Notes: Definitions only.
`ifndef HBP_REGS_SVH
`define HBP_REGS_SVH
// Period of the device clock, in picoseconds.
`define HBP_CLK_PS 10000
// Shortest EISA strobe, in nanoseconds.
`define HBP_EISA_MIN_STROBE_NS 180
// Cycles that fit inside the shortest EISA strobe, rounded down.
`define HBP_EISA_MIN_CYC ((`HBP_EISA_MIN_STROBE_NS * 1000) / `HBP_CLK_PS)
// Default base of the 16-byte I/O window, address bits 15 to 4.
`define HBP_BASE_DEFAULT 12'h0030
// Default number of cycles that a data access needs before it completes.
`define HBP_ACCESS_CYC_DEFAULT 4'h2
`endif

/* File: verilog/hbp_pkg.sv */
// Purpose: Types shared by the host bus port files.
// Assumes: Nothing beyond the constants header.
// Notes: Holds types only.
package hbp_pkg;
  // Bus flavour that the port is strapped for.
  typedef enum logic {HBP_ISA, HBP_EISA} hbp_mode_t;
  // Access sequencer states.
  typedef enum logic [1:0] {HBP_IDLE, HBP_WAIT, HBP_DONE} hbp_state_t;
endpackage

/* File: verilog/hbp_lanes.sv */
// Purpose: Turns byte-lane enables into per-lane select bits.
// Assumes: Enables are active low.
// Notes: Combinational only.
`timescale 1ns/1ps
module hbp_lanes
(
  // Mode and enables.
  input wire logic i_eisa,
  input wire logic [3:0] i_be_n,
  // Selected lanes.
  output logic [3:0] o_lane
);
  // On ISA only the lower two lanes can be used; upper enables are tied high.
  assign o_lane = i_eisa ? ~i_be_n : {2'b00, ~i_be_n[1:0]};
endmodule // hbp_lanes

/* File: verilog/hbp_dma.sv */
// Purpose: Type C slave DMA burst acceptor, one doubleword per bus clock.
// Assumes: Bus clock edges arrive as a one-cycle enable pulse.
// Notes: Wait states from EXRDY postpone the next transfer.
`timescale 1ns/1ps
module hbp_dma
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_reset,
  // Burst control.
  input wire logic i_bclk_en,
  input wire logic i_dma_active,
  input wire logic i_exrdy,
  input wire logic [31:0] i_data,
  // Captured doubleword.
  output logic o_word_valid,
  output logic [31:0] o_word
);
  // A transfer happens on a bus clock tick when the memory side is ready.
  wire take = i_dma_active && i_bclk_en && i_exrdy;
  logic [31:0] word_reg;
  logic valid_reg;

  // Capture one aligned doubleword per accepted tick.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      word_reg <= 32'h0000_0000;
      valid_reg <= 1'b0;
    end
    else
    begin
      valid_reg <= take;
      if (take)
        word_reg <= i_data;
    end
  end

  assign o_word = word_reg;
  assign o_word_valid = valid_reg;

  // A wait state must hold back the capture.
  chk_dma_wait_holds: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_bclk_en && !i_exrdy) |=> !o_word_valid) else $error("DMA took a word during a wait state.");
  chk_dma_peak_rate: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_dma_active && i_bclk_en && i_exrdy) |=> (o_word_valid && o_word == $past(i_data)))
    else $error("DMA missed a ready bus clock.");
endmodule // hbp_dma

/* File: verilog/hbp_port.sv */
// Purpose: ISA and EISA host bus attachment: decode, lanes, strobes, ready.
// Assumes: All pins synchronous to i_mclk; strobes last more than one cycle.
// Notes: Data pins are split into input, output and output enable.
// Behaviour
// - Decode only while I/O qualifier low.
// - Write data taken at strobe trailing edge.
// - Ready drops at strobe, returns when done.
// - ISA byte enables pick lower/upper lanes.
// - Unselected lanes float on reads, ignored writes.
// - Local select driven push-pull on decode match.
// - EISA address latched at address strobe rise.
// - Qualifier transparent while strobe low, held after.
// - EISA I/O accesses never insert waits.
// - DMA bursts one doubleword per bus clock.
// - DMA waits while EXRDY asks waits.
`timescale 1ns/1ps
`include "hbp_regs.svh"
module hbp_port
#(
  parameter logic [11:0] BASE = `HBP_BASE_DEFAULT,
  parameter logic [3:0] ACCESS_CYC = `HBP_ACCESS_CYC_DEFAULT
)
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_reset,
  // Mode strap: high for EISA.
  input wire logic i_eisa_mode,
  // Address and qualification.
  input wire logic [15:1] i_addr,
  input wire logic i_io_space_qualifier_n,
  input wire logic i_address_strobe_n,
  input wire logic i_byte_lane0_enable_n,
  input wire logic i_byte_lane1_enable_n,
  input wire logic i_byte_lane2_enable_n,
  input wire logic i_byte_lane3_enable_n,
  // Strobes.
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  // Data bus pins.
  input wire logic [31:0] i_data,
  output logic [31:0] o_data,
  output logic [3:0] o_data_oe,
  // Ready and local select.
  output logic o_async_ready,
  output logic o_local_device_select_n,
  // DMA burst side.
  input wire logic i_bclk_en,
  input wire logic i_dma_active,
  input wire logic i_exrdy,
  output logic o_dma_valid,
  output logic [31:0] o_dma_word,
  // Internal register side.
  input wire logic [31:0] i_rd_data,
  output logic o_wr_pulse,
  output logic [15:1] o_wr_addr,
  output logic [3:0] o_wr_lanes,
  output logic [31:0] o_wr_data
);
  //////////////////////////////////////////////////////////////////////////////
  // Address and qualifier latching.
  logic [15:1] addr_reg;
  logic qual_reg;
  logic [3:0] be_reg;
  logic ads_prev_reg;
  wire [3:0] be_pins = {i_byte_lane3_enable_n, i_byte_lane2_enable_n,
                        i_byte_lane1_enable_n, i_byte_lane0_enable_n};
  // Rising edge of the address strobe seen on this clock.
  wire ads_rise = i_eisa_mode && !ads_prev_reg && i_address_strobe_n;

  // Holding registers track while the strobe is low and freeze at its rise.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      addr_reg <= 15'h0000;
      qual_reg <= 1'b1;
      be_reg <= 4'hf;
      ads_prev_reg <= 1'b1;
    end
    else
    begin
      ads_prev_reg <= i_address_strobe_n;
      if (!i_address_strobe_n || ads_rise)
      begin
        addr_reg <= {i_addr[15:2], 1'b0};
        qual_reg <= i_io_space_qualifier_n;
        be_reg <= be_pins;
      end
    end
  end

  // EISA sees live values while the strobe is low; ISA sees the pins.
  wire eisa_live = !i_address_strobe_n;
  wire [15:1] addr_eff = !i_eisa_mode ? i_addr : (eisa_live ? {i_addr[15:2], 1'b0} : addr_reg);
  wire qual_eff_n = (!i_eisa_mode || eisa_live) ? i_io_space_qualifier_n : qual_reg;
  wire [3:0] be_eff = (!i_eisa_mode || eisa_live) ? be_pins : be_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Decode and lane selection.
  // Match on bits 15 to 4 only with the qualifier low.
  wire hit = !qual_eff_n && (addr_eff[15:4] == BASE);
  wire [3:0] lanes;

  // Lane selection helper.
  hbp_lanes u_lanes
  (
    .i_eisa(i_eisa_mode),
    .i_be_n(be_eff),
    .o_lane(lanes)
  );

  // Push-pull select, never released.
  assign o_local_device_select_n = !hit;

  //////////////////////////////////////////////////////////////////////////////
  // Access sequencer for ready stretching.
  hbp_pkg::hbp_state_t state_reg, state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic rd_prev_reg;
  logic wr_prev_reg;
  wire rd_act = !i_read_strobe_n && hit && !i_dma_active;
  wire wr_act = !i_write_strobe_n && hit;
  wire strobe_fall = (rd_act && rd_prev_reg) || (wr_act && wr_prev_reg);
  // EISA never waits; ISA waits only when the access needs cycles.
  wire need_wait = !i_eisa_mode && (ACCESS_CYC != 4'h0);

  // Next-state logic; the sequencer returns to idle when the strobe ends.
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      hbp_pkg::HBP_IDLE:
      begin
        if (strobe_fall && need_wait)
        begin
          state_next = hbp_pkg::HBP_WAIT;
          cnt_next = ACCESS_CYC - 4'h1;
        end
      end
      hbp_pkg::HBP_WAIT:
      begin
        // Access condition met on the edge where the count runs out.
        if (cnt_reg == 4'h0)
          state_next = hbp_pkg::HBP_DONE;
        else
          cnt_next = cnt_reg - 4'h1;
      end
      hbp_pkg::HBP_DONE:
      begin
        if (!rd_act && !wr_act)
          state_next = hbp_pkg::HBP_IDLE;
      end
      default:
        state_next = hbp_pkg::HBP_IDLE;
    endcase
  end

  // Ready is low from the strobe edge until the sequencer is done.
  // Combinational so the drop follows the leading edge without a cycle of lag.
  assign o_async_ready = !((strobe_fall && need_wait) || state_reg == hbp_pkg::HBP_WAIT);

  // Sequencer and strobe history registers.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_reg <= hbp_pkg::HBP_IDLE;
      cnt_reg <= 4'h0;
      // Idle level of the strobes, so no false leading edge follows reset.
      rd_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rd_prev_reg <= i_read_strobe_n;
      wr_prev_reg <= i_write_strobe_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write capture at the trailing edge of the write strobe.
  logic wr_seen_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wlanes_reg;
  logic [15:1] waddr_reg;
  logic wpulse_reg;

  // Byte mask that opens the data bits of each selected lane.
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Trailing edge: strobe was low and now is high.
  wire wr_rise = wr_seen_reg && i_write_strobe_n;

  // Track data while the strobe is low so the trailing-edge value is kept.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      wr_seen_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wlanes_reg <= 4'h0;
      waddr_reg <= 15'h0000;
      wpulse_reg <= 1'b0;
    end
    else
    begin
      wr_seen_reg <= wr_act;
      wpulse_reg <= wr_rise;
      if (wr_act)
      begin
        // Unselected lanes are masked so their contents never matter.
        wdata_reg <= i_data & lane_mask(lanes);
        wlanes_reg <= lanes;
        waddr_reg <= addr_eff;
      end
    end
  end

  assign o_wr_pulse = wpulse_reg;
  assign o_wr_data = wdata_reg;
  assign o_wr_lanes = wlanes_reg;
  assign o_wr_addr = waddr_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Read drive: registered data, enables only on a qualified read.
  logic [31:0] rdata_reg;

  // Register read data each cycle so the pins come from flip-flops.
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= i_rd_data;
  end

  assign o_data = rdata_reg;
  // Release the bus the moment the strobe goes away.
  assign o_data_oe = rd_act ? lanes : 4'h0;

  //////////////////////////////////////////////////////////////////////////////
  // DMA burst path.
  hbp_dma u_dma
  (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_bclk_en(i_bclk_en),
    .i_dma_active(i_dma_active),
    .i_exrdy(i_exrdy),
    .i_data(i_data),
    .o_word_valid(o_dma_valid),
    .o_word(o_dma_word)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_qual_blocks_sel: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!i_eisa_mode && i_io_space_qualifier_n) |-> o_local_device_select_n)
    else $error("Select asserted with qualifier high.");
  chk_qual_blocks_drive: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!i_eisa_mode && i_io_space_qualifier_n) |-> (o_data_oe == 4'h0))
    else $error("Data driven with qualifier high.");
  chk_lane_low_only: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!i_eisa_mode && rd_act && !i_byte_lane0_enable_n && i_byte_lane1_enable_n) |-> (o_data_oe == 4'h1))
    else $error("Wrong lanes for lower byte read.");
  chk_lane_high_only: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!i_eisa_mode && rd_act && i_byte_lane0_enable_n && !i_byte_lane1_enable_n) |-> (o_data_oe == 4'h2))
    else $error("Wrong lanes for upper byte read.");
  chk_lane_both: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!i_eisa_mode && rd_act && !i_byte_lane0_enable_n && !i_byte_lane1_enable_n) |-> (o_data_oe == 4'h3))
    else $error("Wrong lanes for word read.");
  chk_read_release: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_read_strobe_n |-> (o_data_oe == 4'h0)) else $error("Lanes driven without read strobe.");
  chk_ready_drop_rise: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_reg == hbp_pkg::HBP_IDLE && strobe_fall && need_wait) |-> !o_async_ready ##1 !o_async_ready)
    else $error("Ready not held low during wait.");
  chk_ready_return: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_reg == hbp_pkg::HBP_IDLE && strobe_fall && need_wait) |-> ##[1:16] o_async_ready)
    else $error("Ready did not return.");
  chk_eisa_no_wait: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_eisa_mode |-> o_async_ready) else $error("EISA access stretched.");
  chk_write_trailing: assert property (@(posedge i_mclk) disable iff (i_reset)
    ($rose(i_write_strobe_n) && wr_seen_reg) |=> (o_wr_pulse && o_wr_data == $past(wdata_reg)))
    else $error("Write not captured at trailing edge.");
  chk_write_lane_mask: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_wr_pulse |-> ((o_wr_data & ~lane_mask(o_wr_lanes)) == 32'h0000_0000))
    else $error("Unselected write lane kept data.");
  chk_eisa_addr_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_eisa_mode && ads_rise) |=> (addr_reg[15:2] == $past(i_addr[15:2])))
    else $error("Address not held at strobe rise.");
  chk_sel_on_match: assert property (@(posedge i_mclk) disable iff (i_reset)
    (!i_eisa_mode && !i_io_space_qualifier_n && i_addr[15:4] == BASE) |-> !o_local_device_select_n)
    else $error("Select missing on decode match.");
endmodule // hbp_port

/* File: tb/hbp_host_model.sv */
// Purpose: Host bus master model that runs ISA and EISA I/O cycles.
// Assumes: It changes its lines 1 ns after a rising clock edge.
// Notes: Released data shows the inverse of the last value.
`timescale 1ns/1ps
module hbp_host_model
(
  // Clock and strap.
  input wire logic i_mclk,
  input wire logic i_eisa,
  // Bus lines towards the port.
  output logic [15:1] o_addr,
  output logic o_qual_n,
  output logic o_ads_n,
  output logic [3:0] o_be_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [31:0] o_data
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle bus: read and write strobes high, address strobe low, all lanes off, qualifier inactive.
  initial
  begin
    o_addr = 15'h0000;
    o_qual_n = 1'b1;
    o_ads_n = 1'b0;
    o_be_n = 4'hf;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_data = 32'h0000_0000;
  end

  // One strobed access; on ISA address and qualifier settle a cycle before the strobe, on EISA they go away a cycle before it.
  task automatic access(input logic wr, input logic q, input logic [15:1] a, input logic [3:0] be,
                        input logic [31:0] d);
    begin
      @(posedge i_mclk);
      #1;
      o_addr = a;
      o_be_n = be;
      o_qual_n = q;
      // The ISA board ties the address strobe low; on EISA it opens low here.
      o_ads_n = 1'b0;
      if (wr)
      begin
        o_data = d;
      end
      if (i_eisa)
      begin
        // The EISA bus moves on after the start strobe, so the port must latch.
        @(posedge i_mclk);
        #1;
        o_ads_n = 1'b1;
        @(posedge i_mclk);
        #1;
        o_addr = ~a;
        o_qual_n = 1'b1;
      end
      @(posedge i_mclk);
      #1;
      // Strobes come from command edges on EISA and straight from the bus on ISA.
      o_wr_n = ~wr;
      o_rd_n = wr;
      repeat (5) @(posedge i_mclk);
      #1;
      o_wr_n = 1'b1;
      o_rd_n = 1'b1;
      @(posedge i_mclk);
      #1;
      o_addr = ~a;
      o_qual_n = 1'b1;
      o_data = ~o_data;
    end
  endtask
endmodule // hbp_host_model

/* File: tb/tb_isa_eisa_host_bus_port.sv */
// Purpose: Self-checking bench for the host bus port.
// Assumes: Default base and access length of the port.
// Notes: Random data from a fixed seed; DMA lines are driven here.
`timescale 1ns/1ps
`include "hbp_regs.svh"
module tb_isa_eisa_host_bus_port;
  // Bench state and counters.
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic eisa = 1'b0;
  logic bclk_en = 1'b0;
  logic dma_act = 1'b0;
  logic exrdy = 1'b1;
  logic [31:0] rd_data = 32'h0000_0000;
  int seed = 46295;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Bus nets and port outputs.
  wire [15:1] addr;
  wire qual_n, ads_n, rd_n, wr_n;
  wire [3:0] be_n;
  wire [31:0] hd, bus;
  logic [31:0] od, dword, wr_data;
  logic [3:0] oe, wr_lanes;
  logic [15:1] wr_addr;
  logic rdy, sel_n, dval, wr_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Byte mask of a lane set.
  function automatic logic [31:0] mask(input logic [3:0] ln);
    return {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
  endfunction

  // Lanes that a set of active-low enables should open.
  function automatic logic [3:0] lanes(input logic e, input logic [3:0] be);
    return e ? ~be : {2'b00, ~be[1:0]};
  endfunction

  // A random address inside the decode window, bit 1 clear.
  function automatic logic [15:1] hit();
    return {`HBP_BASE_DEFAULT, 2'($random(seed)), 1'b0};
  endfunction

  // The pins carry whichever party drives each lane.
  assign bus = (od & mask(oe)) | (hd & ~mask(oe));

  always #5 mclk = ~mclk;

  hbp_host_model host (.i_mclk(mclk), .i_eisa(eisa), .o_addr(addr), .o_qual_n(qual_n), .o_ads_n(ads_n),
    .o_be_n(be_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_data(hd));

  hbp_port uut (.i_mclk(mclk), .i_reset(reset), .i_eisa_mode(eisa), .i_addr(addr),
    .i_io_space_qualifier_n(qual_n), .i_address_strobe_n(ads_n), .i_byte_lane0_enable_n(be_n[0]),
    .i_byte_lane1_enable_n(be_n[1]), .i_byte_lane2_enable_n(be_n[2]), .i_byte_lane3_enable_n(be_n[3]),
    .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_data(bus), .o_data(od), .o_data_oe(oe),
    .o_async_ready(rdy), .o_local_device_select_n(sel_n), .i_bclk_en(bclk_en), .i_dma_active(dma_act),
    .i_exrdy(exrdy), .o_dma_valid(dval), .o_dma_word(dword), .i_rd_data(rd_data), .o_wr_pulse(wr_pulse),
    .o_wr_addr(wr_addr), .o_wr_lanes(wr_lanes), .o_wr_data(wr_data));

  ////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        mismatches++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic final_report();
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
      begin
        $display("ALL CHECKS OK");
      end
      else
      begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask

  // One access with the port watched from strobe to write pulse.
  task automatic xfer(input logic wr, input logic q, input logic [3:0] be);
    logic [15:1] a;
    logic [31:0] d, m;
    logic [3:0] ln;
    int n;
    begin
      a = hit();
      d = $random(seed);
      rd_data = $random(seed);
      ln = q ? 4'h0 : lanes(eisa, be);
      m = mask(ln);
      fork
        host.access(wr, q, a, be, d);
        begin
          while ((wr ? wr_n : rd_n) !== 1'b0) begin @(posedge mclk); #2; end
          @(posedge mclk);
          #2;
          chk(sel_n, q);
          if (!q) chk(rdy, eisa);
          chk(oe, wr ? 4'h0 : ln);
          n = 0;
          while (rdy !== 1'b1 && n < 8) begin @(posedge mclk); #2; n++; end
          chk(rdy, 1'b1);
          if (!wr) chk(od & m, rd_data & m);
          while ((wr ? wr_n : rd_n) !== 1'b1) begin @(posedge mclk); #2; end
          chk(oe, 4'h0);
          n = 0;
          while (wr_pulse !== 1'b1 && n < 4) begin @(posedge mclk); #2; n++; end
          chk(wr_pulse, wr & ~q);
          if (wr && !q) chk({wr_lanes, wr_addr}, {ln, a});
          if (wr && !q) chk(wr_data & m, d & m);
        end
      join
    end
  endtask

  // A hang is cut short well past the expected length of the run.
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, decode, ISA, EISA, DMA.
  initial
  begin
    logic [1:0] tbl [3] = '{2'b00, 2'b01, 2'b10};
    logic pv;
    logic [31:0] pw;
    logic [15:1] a;
    logic q;
    repeat (20) @(posedge mclk);
    #1;
    chk({rdy, oe}, 5'h10);
    reset = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      #1;
      a = i[0] ? hit() : 15'($random(seed));
      q = i[2];
      host.o_addr = a;
      host.o_qual_n = q;
      #1;
      chk(sel_n, !(q == 1'b0 && a[15:4] == `HBP_BASE_DEFAULT));
    end
    for (int i = 0; i < 6; i++)
    begin
      xfer(i[0], 1'b0, {2'b11, tbl[i / 2]});
    end
    xfer(1'b1, 1'b1, 4'hc);
    xfer(1'b0, 1'b1, 4'hc);
    // The strap moves with the same 1 ns delay after an edge as the host model's lines.
    @(posedge mclk);
    #1;
    eisa = 1'b1;
    xfer(1'b0, 1'b0, 4'h0);
    xfer(1'b1, 1'b0, 4'h0);
    xfer(1'b1, 1'b0, 4'($random(seed)));
    @(posedge mclk);
    #1;
    dma_act = 1'b1;
    pv = 1'b0;
    pw = 32'h0000_0000;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge mclk);
      #1;
      chk(dval, pv);
      if (pv) chk(dword, pw);
      bclk_en = (i < 8) ? 1'b1 : 1'($random(seed));
      exrdy = (i < 8) ? 1'b1 : 1'($random(seed));
      host.o_data = $random(seed);
      pv = bclk_en & exrdy;
      pw = host.o_data;
    end
    // The last tick of the burst is checked before the burst ends.
    @(posedge mclk);
    #1;
    chk(dval, pv);
    if (pv) chk(dword, pw);
    dma_act = 1'b0;
    final_report();
  end
endmodule // tb_isa_eisa_host_bus_port
